// [hw/stcm_defines.svh]
// Bit positions, widths and reset values of the upper setup chain segment.
`ifndef STCM_DEFINES_SVH
`define STCM_DEFINES_SVH

`define STCM_CHAIN_W 647
`define STCM_SEG_MSB 646
`define STCM_SEG_LSB 588
`define STCM_SEG_RST 59'h7ff8000000000

`define STCM_EN_TRAILING 588
`define STCM_EN_LEADING 589
`define STCM_SER_DLY 605:602
`define STCM_IO_DLY 609:606
`define STCM_CORE_DLY 613:610
`define STCM_DLL_DLY 617:614
`define STCM_SER_SRC 619:618
`define STCM_IO_SRC 621:620
`define STCM_CORE_SRC 623:622
`define STCM_DLL_SRC 626:624
`define STCM_ROLL_OVER 638:627
`define STCM_EN_MATCH 639
`define STCM_EN_PAIR 640
`define STCM_TTL_SERIAL 641
`define STCM_TTL_CONTROL 642
`define STCM_TTL_RESET 643
`define STCM_TTL_CLOCK 644
`define STCM_TTL_HIT 645
`define STCM_PARITY 646

`define STCM_DLY_SEL_BIT 3
`define STCM_DLY_STEP 2:0
`define STCM_DLL_SRC_MAX 3'h4
`define STCM_ROLL_W 12

`endif

// [hw/stcm_pkg.sv]
// Types shared by the setup chain segment.
`default_nettype none
package stcm_pkg;
  typedef enum logic [1:0] {STCM_SER_PLL80 = 2'h0, STCM_SER_BAD1 = 2'h1, STCM_SER_BAD2 = 2'h2,
    STCM_SER_AUX = 2'h3} stcm_ser_src_e;
  typedef enum logic [1:0] {STCM_IO_EXT40 = 2'h0, STCM_IO_BAD1 = 2'h1, STCM_IO_BAD2 = 2'h2,
    STCM_IO_AUX = 2'h3} stcm_io_src_e;
  typedef enum logic [1:0] {STCM_CORE_EXT40 = 2'h0, STCM_CORE_PLL80 = 2'h1,
    STCM_CORE_PLL160 = 2'h2, STCM_CORE_AUX = 2'h3} stcm_core_src_e;
  typedef enum logic [2:0] {STCM_DLL_EXT40 = 3'h0, STCM_DLL_PLL40 = 3'h1, STCM_DLL_PLL160 = 3'h2,
    STCM_DLL_PLL320 = 3'h3, STCM_DLL_AUX = 3'h4} stcm_dll_src_e;
endpackage
`default_nettype wire

// [hw/stcm_rollover_counter.sv]
// Coarse counter that returns to zero after reaching the programmed roll-over value.
`timescale 1ns/10ps
`default_nettype none
`include "stcm_defines.svh"
module stcm_rollover_counter #(
  parameter int WIDTH = `STCM_ROLL_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] roll_over,
  output logic [WIDTH-1:0] count_q,
  output logic wrap_q
);
  logic [WIDTH-1:0] count_d;
  wire at_limit = (count_q >= roll_over);

  assign count_d = at_limit ? '0 : WIDTH'(count_q + 1'b1);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= '0;
      wrap_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      wrap_q <= at_limit;
    end
  end

  property p_wrap;
    @(posedge clk) disable iff (!reset_n)
    (count_q == roll_over) |=> (count_q == '0) && wrap_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap at roll-over");

  // The edge that releases reset still finds the counter held, so that attempt is left out.
  property p_count_up;
    @(posedge clk) disable iff (!reset_n)
    reset_n && (count_q < roll_over) && $stable(roll_over) |=> (count_q == $past(count_q) + 1'b1);
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter failed to advance");

  c_wrap: cover property (@(posedge clk) disable iff (!reset_n) wrap_q);
endmodule // stcm_rollover_counter
`default_nettype wire

// [hw/stcm_setup_chain.sv]
// Upper setup scan segment: clock skew and source selection, roll-over, matching and levels.
//
// Overview of operation
// - Serial clock skew: top bit picks direct or delayed, low bits count steps.
// - IO clock skew: same encoding, resets to zero.
// - Core clock skew: same encoding, normal setting all zeros.
// - DLL clock skew: same encoding, defaults to zero.
// - Serial clock source: 00 multiplied 80 MHz, 11 auxiliary; others invalid.
// - IO clock source: 00 external 40 MHz, 11 auxiliary; others invalid.
// - Core clock source: external 40, PLL 80, PLL 160, or auxiliary.
// - DLL clock source: external 40, PLL 40, 160, 320, or auxiliary.
// - Counters wrap to zero after the twelve-bit roll-over value, reset all ones.
// - One bit enables trigger matching of recorded hits.
// - Pairing bit combines edges, overriding separate leading and trailing enables.
// - Serial level bit selects single-ended inputs and disables differential drivers.
// - Separate bits select single-ended control, reset, clock and hit inputs.
// - Top chain bit is even parity over all setup data.
`timescale 1ns/10ps
`default_nettype none
`include "stcm_defines.svh"
module stcm_setup_chain (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scan_shift,
  input wire logic scan_update,
  input wire logic scan_in,
  output logic scan_out,
  output logic serial_clk_delayed,
  output logic [2:0] serial_clk_steps,
  output logic io_clk_delayed,
  output logic [2:0] io_clk_steps,
  output logic core_clk_delayed,
  output logic [2:0] core_clk_steps,
  output logic dll_clk_delayed,
  output logic [2:0] dll_clk_steps,
  output stcm_pkg::stcm_ser_src_e serial_clk_source,
  output logic serial_clk_source_invalid,
  output stcm_pkg::stcm_io_src_e io_clk_source,
  output logic io_clk_source_invalid,
  output stcm_pkg::stcm_core_src_e core_clk_source,
  output stcm_pkg::stcm_dll_src_e dll_clk_source,
  output logic dll_clk_source_invalid,
  output logic [`STCM_ROLL_W-1:0] roll_over_value,
  output logic [`STCM_ROLL_W-1:0] coarse_count,
  output logic coarse_wrap,
  output logic match_enable,
  output logic pair_enable,
  output logic leading_enable,
  output logic trailing_enable,
  output logic serial_single_ended,
  output logic serial_diff_drive_en,
  output logic control_single_ended,
  output logic reset_single_ended,
  output logic clock_single_ended,
  output logic hit_single_ended,
  output logic setup_parity_error_q
);
  logic [`STCM_CHAIN_W-1:0] shift_q;
  logic [`STCM_CHAIN_W-1:0] shift_d;
  logic [`STCM_SEG_MSB:`STCM_SEG_LSB] cfg_q;
  logic [`STCM_SEG_MSB:`STCM_SEG_LSB] cfg_d;
  logic parity_err_d;
  logic [3:0] ser_dly;
  logic [3:0] io_dly;
  logic [3:0] core_dly;
  logic [3:0] dll_dly;

  // The chain shifts toward bit zero; the new bit enters at the parity end.
  assign shift_d = scan_shift ? {scan_in, shift_q[`STCM_CHAIN_W-1:1]} : shift_q;
  // Settings change only on update so shifting never disturbs the running clocks.
  assign cfg_d = scan_update ? shift_q[`STCM_SEG_MSB:`STCM_SEG_LSB] : cfg_q;
  assign parity_err_d = scan_update ? (^shift_q) : setup_parity_error_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_q <= '0;
      cfg_q <= `STCM_SEG_RST;
      setup_parity_error_q <= 1'b0;
    end
    else
    begin
      shift_q <= shift_d;
      cfg_q <= cfg_d;
      setup_parity_error_q <= parity_err_d;
    end
  end

  assign scan_out = shift_q[0];

  // A part-select cannot be selected again, so each skew field gets its own wire.
  assign ser_dly = cfg_q[`STCM_SER_DLY];
  assign io_dly = cfg_q[`STCM_IO_DLY];
  assign core_dly = cfg_q[`STCM_CORE_DLY];
  assign dll_dly = cfg_q[`STCM_DLL_DLY];
  assign serial_clk_delayed = ser_dly[`STCM_DLY_SEL_BIT];
  assign serial_clk_steps = ser_dly[`STCM_DLY_STEP];
  assign io_clk_delayed = io_dly[`STCM_DLY_SEL_BIT];
  assign io_clk_steps = io_dly[`STCM_DLY_STEP];
  assign core_clk_delayed = core_dly[`STCM_DLY_SEL_BIT];
  assign core_clk_steps = core_dly[`STCM_DLY_STEP];
  assign dll_clk_delayed = dll_dly[`STCM_DLY_SEL_BIT];
  assign dll_clk_steps = dll_dly[`STCM_DLY_STEP];

  assign serial_clk_source = stcm_pkg::stcm_ser_src_e'(cfg_q[`STCM_SER_SRC]);
  assign serial_clk_source_invalid = (serial_clk_source == stcm_pkg::STCM_SER_BAD1) ||
    (serial_clk_source == stcm_pkg::STCM_SER_BAD2);
  assign io_clk_source = stcm_pkg::stcm_io_src_e'(cfg_q[`STCM_IO_SRC]);
  assign io_clk_source_invalid = (io_clk_source == stcm_pkg::STCM_IO_BAD1) ||
    (io_clk_source == stcm_pkg::STCM_IO_BAD2);
  assign core_clk_source = stcm_pkg::stcm_core_src_e'(cfg_q[`STCM_CORE_SRC]);
  assign dll_clk_source = stcm_pkg::stcm_dll_src_e'(cfg_q[`STCM_DLL_SRC]);
  assign dll_clk_source_invalid = (cfg_q[`STCM_DLL_SRC] > `STCM_DLL_SRC_MAX);

  assign roll_over_value = cfg_q[`STCM_ROLL_OVER];

  stcm_rollover_counter #(
    .WIDTH(`STCM_ROLL_W)
  ) u_coarse (
    .clk(clk),
    .reset_n(reset_n),
    .roll_over(roll_over_value),
    .count_q(coarse_count),
    .wrap_q(coarse_wrap)
  );

  assign match_enable = cfg_q[`STCM_EN_MATCH];
  assign pair_enable = cfg_q[`STCM_EN_PAIR];
  assign leading_enable = pair_enable | cfg_q[`STCM_EN_LEADING];
  assign trailing_enable = pair_enable | cfg_q[`STCM_EN_TRAILING];

  assign serial_single_ended = cfg_q[`STCM_TTL_SERIAL];
  assign serial_diff_drive_en = ~cfg_q[`STCM_TTL_SERIAL];
  assign control_single_ended = cfg_q[`STCM_TTL_CONTROL];
  assign reset_single_ended = cfg_q[`STCM_TTL_RESET];
  assign clock_single_ended = cfg_q[`STCM_TTL_CLOCK];
  assign hit_single_ended = cfg_q[`STCM_TTL_HIT];

  property p_shift;
    @(posedge clk) disable iff (!reset_n)
    scan_shift |=> (shift_q[`STCM_CHAIN_W-2:0] == $past(shift_q[`STCM_CHAIN_W-1:1]))
      && (shift_q[`STCM_CHAIN_W-1] == $past(scan_in));
  endproperty
  a_shift: assert property (p_shift) else $error("chain did not shift by one bit");

  property p_ser_skew;
    @(posedge clk) disable iff (!reset_n)
    scan_update |=> ({serial_clk_delayed, serial_clk_steps}
      == $past(shift_q[`STCM_SER_DLY]));
  endproperty
  a_ser_skew: assert property (p_ser_skew) else $error("serial skew not loaded");

  property p_dll_skew;
    @(posedge clk) disable iff (!reset_n)
    scan_update |=> ({dll_clk_delayed, dll_clk_steps} == $past(shift_q[`STCM_DLL_DLY]))
      && ({io_clk_delayed, io_clk_steps} == $past(shift_q[`STCM_IO_DLY]))
      && ({core_clk_delayed, core_clk_steps} == $past(shift_q[`STCM_CORE_DLY]));
  endproperty
  a_dll_skew: assert property (p_dll_skew) else $error("skew fields not loaded");

  property p_ser_invalid;
    @(posedge clk) disable iff (!reset_n)
    scan_update && (shift_q[`STCM_SER_SRC] == 2'h1) |=> serial_clk_source_invalid;
  endproperty
  a_ser_invalid: assert property (p_ser_invalid) else $error("serial code not flagged");

  property p_io_valid;
    @(posedge clk) disable iff (!reset_n)
    scan_update && (shift_q[`STCM_IO_SRC] == 2'h3) |=> !io_clk_source_invalid
      && (io_clk_source == stcm_pkg::STCM_IO_AUX);
  endproperty
  a_io_valid: assert property (p_io_valid) else $error("io aux code mishandled");

  property p_dll_invalid;
    @(posedge clk) disable iff (!reset_n)
    scan_update && (shift_q[`STCM_DLL_SRC] > `STCM_DLL_SRC_MAX) |=> dll_clk_source_invalid;
  endproperty
  a_dll_invalid: assert property (p_dll_invalid) else $error("dll code not flagged");

  property p_hold;
    @(posedge clk) disable iff (!reset_n)
    !scan_update |=> $stable(roll_over_value) && $stable(core_clk_source)
      && $stable(match_enable);
  endproperty
  a_hold: assert property (p_hold) else $error("settings changed without update");

  property p_pair;
    @(posedge clk) disable iff (!reset_n)
    scan_update && shift_q[`STCM_EN_PAIR] |=> leading_enable && trailing_enable && pair_enable;
  endproperty
  a_pair: assert property (p_pair) else $error("pairing did not force both edges");

  property p_parity;
    @(posedge clk) disable iff (!reset_n)
    scan_update |=> (setup_parity_error_q == $past(^shift_q));
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");

  property p_levels;
    @(posedge clk) disable iff (!reset_n)
    scan_update |=> (serial_diff_drive_en == !$past(shift_q[`STCM_TTL_SERIAL]))
      && (hit_single_ended == $past(shift_q[`STCM_TTL_HIT]))
      && (match_enable == $past(shift_q[`STCM_EN_MATCH]));
  endproperty
  a_levels: assert property (p_levels) else $error("level or matching bit not loaded");

  c_update: cover property (@(posedge clk) disable iff (!reset_n) scan_update);
  c_parity_err: cover property (@(posedge clk) disable iff (!reset_n) setup_parity_error_q);
  c_pll320: cover property (@(posedge clk) disable iff (!reset_n)
    dll_clk_source == stcm_pkg::STCM_DLL_PLL320);
endmodule // stcm_setup_chain
`default_nettype wire

// [verif/stcm_host_model.sv]
// Serial host model that loads the setup chain, bit 0 first.
`timescale 1ns/10ps
`default_nettype none
module stcm_host_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic bad_par,
  input wire logic [646:0] img,
  output logic busy,
  output logic scan_shift,
  output logic scan_update,
  output logic scan_in
);
  logic [646:0] fix;
  logic [646:0] sh_q;
  logic [9:0] n_q;
  always_comb
  begin
    fix = img;
    fix[593:592] = (img[626:624] == 3'h3) ? 2'h2 : ((img[626:624] == 3'h2) ? 2'h1 : 2'h0);
    if (img[640])
      fix[591] = 1'h0;
    fix[646] = bad_par ^ (^fix[645:0]);
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy <= 1'h0;
      scan_shift <= 1'h0;
      scan_update <= 1'h0;
      scan_in <= 1'h0;
      n_q <= 10'h0;
      sh_q <= '0;
    end
    else
    begin
      scan_update <= 1'h0;
      if (start && !busy)
      begin
        busy <= 1'h1;
        sh_q <= fix;
        n_q <= 10'h0;
        scan_shift <= 1'h1;
        scan_in <= fix[0];
      end
      else if (busy && scan_shift && n_q == 10'h286)
      begin
        scan_shift <= 1'h0;
        scan_update <= 1'h1;
        // The line is released, so it must not keep showing the last bit.
        scan_in <= ~scan_in;
      end
      else if (busy && scan_shift)
      begin
        n_q <= n_q + 10'h1;
        sh_q <= sh_q >> 1;
        scan_in <= sh_q[1];
      end
      else
        busy <= 1'h0;
    end
  end
endmodule // stcm_host_model
`default_nettype wire

// [verif/tb_setup_clock_mode_config_fields.sv]
// Self-checking bench for the setup chain segment.
`timescale 1ns/10ps
`default_nettype none
module tb_setup_clock_mode_config_fields;
  typedef struct packed {logic [3:0] dly; logic [1:0] ss; logic [1:0] is; logic [1:0] cs;
    logic [2:0] ds; logic [11:0] ro; logic [8:0] fl; logic [2:0] inv;} stcm_row_s;
  logic clk, reset_n, scan_shift, scan_update, scan_in, scan_out, start, bad, busy;
  logic serial_clk_delayed, io_clk_delayed, core_clk_delayed, dll_clk_delayed;
  logic [2:0] serial_clk_steps, io_clk_steps, core_clk_steps, dll_clk_steps;
  logic [1:0] serial_clk_source, io_clk_source, core_clk_source;
  logic [2:0] dll_clk_source;
  logic serial_clk_source_invalid, io_clk_source_invalid, dll_clk_source_invalid, coarse_wrap;
  logic [11:0] roll_over_value, coarse_count;
  logic match_enable, pair_enable, leading_enable, trailing_enable, serial_single_ended;
  logic serial_diff_drive_en, control_single_ended, reset_single_ended, clock_single_ended;
  logic hit_single_ended, setup_parity_error_q;
  logic [646:0] img;
  int error_cnt = 0;
  int n_compared = 0;
  stcm_row_s rows [8] = '{
    '{4'h0, 2'h0, 2'h0, 2'h0, 3'h0, 12'hfff, 9'h000, 3'h0},
    '{4'h9, 2'h1, 2'h1, 2'h1, 3'h1, 12'h123, 9'h0ff, 3'h6},
    '{4'hf, 2'h2, 2'h2, 2'h2, 3'h2, 12'h000, 9'h100, 3'h6},
    '{4'h7, 2'h3, 2'h3, 2'h3, 3'h3, 12'h800, 9'h080, 3'h0},
    '{4'h8, 2'h0, 2'h3, 2'h1, 3'h4, 12'h001, 9'h155, 3'h0},
    '{4'h1, 2'h3, 2'h0, 2'h2, 3'h5, 12'h7ff, 9'h0aa, 3'h1},
    '{4'hc, 2'h0, 2'h0, 2'h3, 3'h6, 12'hffe, 9'h002, 3'h1},
    '{4'h3, 2'h1, 2'h2, 2'h0, 3'h7, 12'h002, 9'h001, 3'h7}};
  stcm_setup_chain u_dut (.clk(clk), .reset_n(reset_n), .scan_shift(scan_shift),
    .scan_update(scan_update), .scan_in(scan_in), .scan_out(scan_out),
    .serial_clk_delayed(serial_clk_delayed), .serial_clk_steps(serial_clk_steps),
    .io_clk_delayed(io_clk_delayed), .io_clk_steps(io_clk_steps),
    .core_clk_delayed(core_clk_delayed), .core_clk_steps(core_clk_steps),
    .dll_clk_delayed(dll_clk_delayed), .dll_clk_steps(dll_clk_steps),
    .serial_clk_source(serial_clk_source),
    .serial_clk_source_invalid(serial_clk_source_invalid),
    .io_clk_source(io_clk_source), .io_clk_source_invalid(io_clk_source_invalid),
    .core_clk_source(core_clk_source), .dll_clk_source(dll_clk_source),
    .dll_clk_source_invalid(dll_clk_source_invalid), .roll_over_value(roll_over_value),
    .coarse_count(coarse_count), .coarse_wrap(coarse_wrap), .match_enable(match_enable),
    .pair_enable(pair_enable), .leading_enable(leading_enable),
    .trailing_enable(trailing_enable), .serial_single_ended(serial_single_ended),
    .serial_diff_drive_en(serial_diff_drive_en), .control_single_ended(control_single_ended),
    .reset_single_ended(reset_single_ended), .clock_single_ended(clock_single_ended),
    .hit_single_ended(hit_single_ended), .setup_parity_error_q(setup_parity_error_q));
  stcm_host_model u_host (.clk(clk), .reset_n(reset_n), .start(start), .bad_par(bad),
    .img(img), .busy(busy), .scan_shift(scan_shift), .scan_update(scan_update),
    .scan_in(scan_in));
  always #5 clk = ~clk;
  task end_sim;
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [646:0] mk(input stcm_row_s r);
    logic [646:0] m;
    m = '0;
    m[0] = r.dly[0];
    m[589:588] = r.fl[8:7];
    m[605:602] = r.dly;
    m[609:606] = ~r.dly;
    m[613:610] = r.dly ^ 4'h5;
    m[617:614] = r.dly ^ 4'ha;
    m[626:618] = {r.ds, r.cs, r.is, r.ss};
    m[638:627] = r.ro;
    m[645:639] = r.fl[6:0];
    return m;
  endfunction
  // Waits for the host to finish; the bound covers 647 shifts plus the update.
  task automatic load(input logic [646:0] m, input logic b);
    int k;
    @(posedge clk);
    img <= m;
    bad <= b;
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    @(negedge clk);
    k = 0;
    while (busy !== 1'h0 && k < 700)
    begin
      @(negedge clk);
      k++;
    end
    chk(busy, 1'h0);
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    end_sim;
  end
  initial
  begin
    stcm_row_s r;
    int k;
    clk = 1'h0;
    reset_n = 1'h0;
    start = 1'h0;
    bad = 1'h0;
    img = '0;
    repeat (19) @(posedge clk);
    chk({roll_over_value, serial_diff_drive_en}, {12'hfff, 1'h1});
    chk({setup_parity_error_q, scan_out, io_clk_delayed, io_clk_steps}, 6'h0);
    @(posedge clk);
    reset_n <= 1'h1;
    foreach (rows[i])
    begin
      r = rows[i];
      load(mk(r), 1'h0);
      chk({serial_clk_delayed, serial_clk_steps}, r.dly);
      chk({io_clk_delayed, io_clk_steps}, 4'(~r.dly));
      chk({core_clk_delayed, core_clk_steps}, r.dly ^ 4'h5);
      chk({dll_clk_delayed, dll_clk_steps}, r.dly ^ 4'ha);
      chk({serial_clk_source, serial_clk_source_invalid}, {r.ss, r.inv[2]});
      chk({io_clk_source, io_clk_source_invalid}, {r.is, r.inv[1]});
      chk(core_clk_source, r.cs);
      chk({dll_clk_source, dll_clk_source_invalid}, {r.ds, r.inv[0]});
      chk(roll_over_value, r.ro);
      chk(match_enable, r.fl[0]);
      chk({pair_enable, leading_enable, trailing_enable}, {r.fl[1], r.fl[1] | r.fl[8],
        r.fl[1] | r.fl[7]});
      chk({serial_single_ended, serial_diff_drive_en}, {r.fl[2], ~r.fl[2]});
      chk({hit_single_ended, clock_single_ended, reset_single_ended, control_single_ended},
        r.fl[6:3]);
      chk(setup_parity_error_q, 1'h0);
      chk(scan_out, r.dly[0]);
    end
    k = 0;
    while (coarse_count !== 12'h2 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    chk({coarse_wrap, coarse_count}, 13'h2);
    @(negedge clk);
    chk({coarse_wrap, coarse_count}, 13'h1000);
    // A bad parity still loads the settings, so both are seen together.
    load(mk(rows[1]), 1'h1);
    chk({setup_parity_error_q, roll_over_value}, 13'h1123);
    load(mk(rows[0]), 1'h0);
    chk(setup_parity_error_q, 1'h0);
    // A reset in mid-run must drop a pending parity error and restore the defaults.
    load(mk(rows[4]), 1'h1);
    chk({setup_parity_error_q, match_enable, roll_over_value}, 14'h3001);
    @(posedge clk);
    reset_n <= 1'h0;
    @(negedge clk);
    chk({setup_parity_error_q, match_enable, roll_over_value}, 14'h0fff);
    chk({coarse_wrap, coarse_count, scan_out}, 14'h0);
    @(posedge clk);
    reset_n <= 1'h1;
    load(mk(rows[3]), 1'h0);
    chk({setup_parity_error_q, roll_over_value}, 13'h0800);
    end_sim;
  end
endmodule // tb_setup_clock_mode_config_fields
`default_nettype wire
